// file: plec_defs.svh
// Offsets, field positions, reset values and timing counts for the loop event and low-power control
// Contract
// - In automatic bandwidth mode, every lock indicator toggle sets the change flag.
// - Interrupt enable bit gates the change flag onto the interrupt output.
// - Change flag sets on lock change whether interrupts are enabled or not.
// - Automatic mode off: no interrupt, change flag reads zero.
// - Selecting the VCO clock is accepted even while unlocked.
// - Wait instruction leaves clock state, selection and loop untouched.
// - Stop with oscillator disabled stops oscillator and loop, forces outputs low.
// - Stop while VCO drives output clears the base clock select bit.
// - After stop, oscillator drives output and select stays clear until software sets it.
// - Stop with oscillator kept running shuts loop but keeps oscillator clock.
// - In break with clear-enable high, accesses clear the change flag normally.
// - A flag cleared during break stays cleared after break ends.
// - In break with clear-enable low, control accesses leave the change flag alone.
// - Outside protected break, any control register read clears the change flag.
// - Select cannot be set while loop off; loop-on cannot clear while select set.
// - In automatic mode the lock indicator is read-only, set when VCO is on frequency.
`ifndef PLEC_DEFS_SVH
`define PLEC_DEFS_SVH
`define PLEC_OFF_CTL 12'h000
`define PLEC_OFF_BWC 12'h004
`define PLEC_BIT_IE 7
`define PLEC_BIT_FLAG 6
`define PLEC_BIT_LOOPON 5
`define PLEC_BIT_BCS 4
`define PLEC_BIT_AUTO 7
`define PLEC_BIT_LOCK 6
`define PLEC_BIT_ACQ 5
`define PLEC_LOOPON_RST 1'b1
`define PLEC_DIV_OSC 2'h2
`define PLEC_DIV_VCO 2'h3
`endif

// file: plec_pkg.sv
// Types for the loop event and low-power control
package plec_pkg;
  typedef enum logic [1:0] {
    PLEC_RUN = 2'b00,
    PLEC_STOP = 2'b01,
    PLEC_WAKE = 2'b11
  } plec_mode_type;
  typedef struct packed {
    logic irq_en;
    logic flag;
    logic loop_on;
    logic base_clock_select;
    logic auto_bw;
    logic acq_man;
    logic lock_s1;
    logic lock_s2;
    logic lock_d;
    plec_mode_type mode;
  } plec_state_type;
endpackage : plec_pkg

// file: plec_clk_if.sv
// Clock divider control signals between the control block and its divider
`timescale 1ns/1ps
interface plec_clk_if;
  logic use_vco;
  logic vco_run;
  logic osc_run;
  logic out_clk;
  logic vco_clk;
  logic osc_clk;
  modport ctl (output use_vco, output vco_run, output osc_run, input out_clk, input vco_clk, input osc_clk);
  modport div (input use_vco, input vco_run, input osc_run, output out_clk, output vco_clk, output osc_clk);
endinterface : plec_clk_if

// file: plec_clkdiv.sv
// Output clock divider: oscillator by two or VCO by three, gated in stop unless the oscillator is kept running
`timescale 1ns/1ps
`include "plec_defs.svh"
module plec_clkdiv
  import plec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  plec_clk_if.div cif
);
  typedef struct packed {
    logic [1:0] cnt;
    logic out;
    logic vco;
    logic osc;
  } plec_div_type;
  plec_div_type s_r, s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.osc = cif.osc_run ? ~s_r.osc : 1'b0;
    s_nxt.vco = cif.vco_run ? ~s_r.vco : 1'b0;
    if (!cif.osc_run)
    begin
      s_nxt.cnt = 2'h0;
      s_nxt.out = 1'b0;
    end
    else if (s_r.cnt == (cif.use_vco ? `PLEC_DIV_VCO : `PLEC_DIV_OSC) - 2'h1)
    begin
      s_nxt.cnt = 2'h0;
      s_nxt.out = ~s_r.out;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 2'h1;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign cif.out_clk = s_r.out;
  assign cif.vco_clk = s_r.vco;
  assign cif.osc_clk = s_r.osc;
endmodule : plec_clkdiv

// file: plec_top.sv
// Loop event flag, interrupt, clock select and stop handling with APB registers
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "plec_defs.svh"
module plec_top
  import plec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog loop and system
  input wire logic loop_settled,
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic wait_req,
  input wire logic osc_run_in_stop_enable,
  input wire logic break_active,
  input wire logic break_clear_enable,
  // Outputs
  output logic generator_irq,
  output logic generator_output_clock,
  output logic vco_clock,
  output logic oscillator_clock,
  output logic loop_enable
);
  plec_state_type s_r, s_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pslverr_r, irq_r, lpe_r;
  logic out_r, vco_r, osc_r;
  logic acc, wr, rd, hit_ctl, hit_bwc, protect;
  logic in_stop;
  plec_clk_if cif ();

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  plec_clkdiv u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .cif(cif)
  );

  // Every access acts in its first access cycle; pready answers one cycle later
  always_comb
  begin
    acc = psel & penable & ~pready_r;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    hit_ctl = is_reg(paddr, `PLEC_OFF_CTL);
    hit_bwc = is_reg(paddr, `PLEC_OFF_BWC);
    protect = break_active & ~break_clear_enable;
    in_stop = (s_r.mode == PLEC_STOP);
  end

  always_comb
  begin
    s_nxt = s_r;
    prdata_nxt = 32'h0000_0000;
    // Two flops before the lock indicator is compared
    s_nxt.lock_s1 = loop_settled;
    s_nxt.lock_s2 = s_r.lock_s1;
    s_nxt.lock_d = s_r.lock_s2;
    // Reads return the state before this access acts on it
    if (rd && hit_ctl)
    begin
      prdata_nxt[`PLEC_BIT_IE] = s_r.irq_en;
      prdata_nxt[`PLEC_BIT_FLAG] = s_r.flag & s_r.auto_bw;
      prdata_nxt[`PLEC_BIT_LOOPON] = s_r.loop_on;
      prdata_nxt[`PLEC_BIT_BCS] = s_r.base_clock_select;
    end
    if (rd && hit_bwc)
    begin
      prdata_nxt[`PLEC_BIT_AUTO] = s_r.auto_bw;
      prdata_nxt[`PLEC_BIT_LOCK] = s_r.lock_s2 & s_r.auto_bw;
      prdata_nxt[`PLEC_BIT_ACQ] = s_r.auto_bw ? s_r.lock_s2 : s_r.acq_man;
    end
    // Clearing is by reading; flag bit is not writable
    if (rd && hit_ctl && !protect)
      s_nxt.flag = 1'b0;
    if (wr && hit_ctl)
    begin
      s_nxt.irq_en = pwdata[`PLEC_BIT_IE];
      // Write to select is taken regardless of lock
      if (pwdata[`PLEC_BIT_BCS] && s_r.loop_on)
        s_nxt.base_clock_select = 1'b1;
      else if (!pwdata[`PLEC_BIT_BCS])
        s_nxt.base_clock_select = 1'b0;
      if (pwdata[`PLEC_BIT_LOOPON])
        s_nxt.loop_on = 1'b1;
      else if (!s_r.base_clock_select && !s_nxt.base_clock_select)
        s_nxt.loop_on = 1'b0;
    end
    if (wr && hit_bwc)
    begin
      s_nxt.auto_bw = pwdata[`PLEC_BIT_AUTO];
      if (!s_r.auto_bw)
        s_nxt.acq_man = pwdata[`PLEC_BIT_ACQ];
    end
    // Event set after the clear so that a simultaneous lock change is not lost
    if (s_r.auto_bw && (s_r.lock_s2 != s_r.lock_d))
      s_nxt.flag = 1'b1;
    // Wait input only blocks entry to stop; it changes nothing on its own
    case (s_r.mode)
      PLEC_RUN:
      begin
        if (stop_req && !wait_req)
        begin
          s_nxt.mode = PLEC_STOP;
          s_nxt.base_clock_select = 1'b0;
        end
      end
      PLEC_STOP:
      begin
        s_nxt.base_clock_select = 1'b0;
        if (wake_req)
          s_nxt.mode = PLEC_WAKE;
      end
      PLEC_WAKE:
      begin
        s_nxt.mode = PLEC_RUN;
      end
      default:
      begin
        s_nxt.mode = PLEC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.loop_on <= `PLEC_LOOPON_RST;
      s_r.mode <= PLEC_RUN;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      lpe_r <= 1'b0;
      out_r <= 1'b0;
      vco_r <= 1'b0;
      osc_r <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= acc;
      pslverr_r <= acc & ~(hit_ctl | hit_bwc);
      // Flag, enable and auto must all hold; stop with oscillator off forces it low
      irq_r <= s_nxt.flag & s_nxt.irq_en & s_nxt.auto_bw
               & ~((s_nxt.mode == PLEC_STOP) & ~osc_run_in_stop_enable);
      lpe_r <= s_nxt.loop_on & (s_nxt.mode != PLEC_STOP);
      out_r <= cif.out_clk;
      vco_r <= cif.vco_clk;
      osc_r <= cif.osc_clk;
    end
  end

  // Divider is steered from registered state and the unregistered osc_run_in_stop_enable input
  assign cif.use_vco = s_r.base_clock_select;
  assign cif.vco_run = s_r.loop_on & ~in_stop;
  assign cif.osc_run = ~in_stop | osc_run_in_stop_enable;

  // pready is registered so each access takes one wait cycle
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign generator_irq = irq_r;
  assign generator_output_clock = out_r;
  assign vco_clock = vco_r;
  assign oscillator_clock = osc_r;
  assign loop_enable = lpe_r;
endmodule : plec_top

// file: plec_top_asserts.sv
// Port assertions for the loop event and low-power control
`timescale 1ns/1ps
`include "plec_defs.svh"
module plec_top_asserts
(
  // Clock, reset and bus
  input wire logic clk_sys, srst, psel, penable, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Mode inputs and outputs
  input wire logic stop_req, wake_req, wait_req, osc_run_in_stop_enable,
  input wire logic generator_irq, vco_clock, loop_enable
);
  logic st;
  assign st = stop_req && !wait_req && !wake_req;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  bus_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer timing");
  unmapped_err_a: assert property (psel && penable && !pready && paddr > `PLEC_OFF_BWC |=> pslverr)
    else $error("unmapped without error");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside answer");
  stop_loop_a: assert property (st |-> ##[1:3] !loop_enable)
    else $error("loop on in stop");
  stop_quiet_a: assert property (st && !osc_run_in_stop_enable |-> ##[1:3] (!generator_irq && !vco_clock))
    else $error("outputs live in stop");
  vco_run_a: assert property (loop_enable && $past(loop_enable) && $past(loop_enable, 2) && $past(loop_enable, 3) |->
    vco_clock != $past(vco_clock)) else $error("vco clock stalled");
  wait_hold_a: assert property ((wait_req && !psel) [*3] |-> $stable(loop_enable))
    else $error("wait changed loop");
  irq_hold_a: assert property (generator_irq && !psel && !$past(psel) && !stop_req |=> generator_irq)
    else $error("irq dropped");
  irq_seen_c: cover property (generator_irq);
  err_seen_c: cover property (pslverr);
  stop_seen_c: cover property (st ##3 !loop_enable);
endmodule : plec_top_asserts
bind plec_top plec_top_asserts u_chk (.clk_sys, .srst, .psel, .penable, .pready, .pslverr, .paddr, .prdata,
  .stop_req, .wake_req, .wait_req, .osc_run_in_stop_enable, .generator_irq, .vco_clock, .loop_enable);

// file: plec_loop_model.sv
// Behavioural analog loop that settles a while after it is switched on
`timescale 1ns/1ps
module plec_loop_model
(
  // Clock and reset
  input wire logic clk_sys, srst,
  // Loop side; lose models a noise hit that drops lock
  input wire logic loop_enable, lose,
  output logic loop_settled
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk_sys)
  begin
    cnt_r <= (srst || !loop_enable) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
    loop_settled <= !srst && loop_enable && cnt_r == 4'hF && !lose;
  end
endmodule : plec_loop_model

// file: test_plec_top.sv
// Bench for the loop event and low-power control
`timescale 1ns/1ps
module test_plec_top;
  typedef struct packed {logic w; logic [11:0] ad; logic [7:0] d; logic [7:0] e; logic s;} plec_row_type;
  plec_row_type rows [9];
  logic clk_sys, srst, psel, penable, pwrite, stop_req, wake_req, wait_req, osc_en, brk, bce, lose, er, a;
  logic pready, pslverr, generator_irq, generator_output_clock, vco_clock, oscillator_clock, loop_enable, loop_settled;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total = 0;
  int tests_run = 0;
  plec_top DUT (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .loop_settled,
    .stop_req, .wake_req, .wait_req, .osc_run_in_stop_enable(osc_en), .break_active(brk), .break_clear_enable(bce),
    .generator_irq, .generator_output_clock, .vco_clock, .oscillator_clock, .loop_enable);
  plec_loop_model MDL (.clk_sys, .srst, .loop_enable, .lose, .loop_settled);
  task pause(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : pause
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    pause(1);
    penable <= 1'h1;
    do
      pause(1);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pause(1);
  endtask : apb
  task rc(input logic [11:0] ad, input logic [7:0] x);
    apb(1'h0, ad, 8'h0);
    chk("rdata", rd, {24'h0, x});
  endtask : rc
  task wake;
    stop_req <= 1'h0;
    wake_req <= 1'h1;
    pause(1);
    wake_req <= 1'h0;
    pause(4);
  endtask : wake
  task wrap_up;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    pause(3000);
    err_total++;
    wrap_up();
  end
  initial
  begin
    {srst, psel, penable, pwrite, stop_req, wake_req, wait_req, osc_en, brk, bce, lose} = 11'h400;
    paddr = 12'h0;
    pwdata = 32'h0;
    rows = '{'{1'h0,12'h000,8'h00,8'h20,1'h0}, '{1'h0,12'h004,8'h00,8'h00,1'h0},
      '{1'h1,12'h008,8'hFF,8'h00,1'h1}, '{1'h1,12'h000,8'h00,8'h00,1'h0}, '{1'h1,12'h000,8'h10,8'h00,1'h0},
      '{1'h1,12'h000,8'h30,8'h20,1'h0}, '{1'h1,12'h000,8'h10,8'h30,1'h0}, '{1'h1,12'h000,8'h20,8'h20,1'h0},
      '{1'h1,12'h004,8'h20,8'h20,1'h0}};
    pause(8);
    srst <= 1'h0;
    pause(1);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'h1, rows[i].ad, rows[i].d);
      rc(rows[i].ad, rows[i].e);
      chk("slverr", {31'h0, er}, {31'h0, rows[i].s});
    end
    // Lock is waited for once here; the later switch to the VCO clock is written while lose holds lock off
    while (loop_settled !== 1'h1) pause(1);
    apb(1'h1, 12'h004, 8'h80);
    rc(12'h004, 8'hE0);
    lose <= 1'h1;
    pause(6);
    rc(12'h000, 8'h60);
    rc(12'h000, 8'h20);
    apb(1'h1, 12'h000, 8'hA0);
    lose <= 1'h0;
    pause(24);
    chk("irq", {31'h0, generator_irq}, 32'h1);
    rc(12'h004, 8'hE0);
    brk <= 1'h1;
    rc(12'h000, 8'hE0);
    rc(12'h000, 8'hE0);
    bce <= 1'h1;
    rc(12'h000, 8'hE0);
    brk <= 1'h0;
    rc(12'h000, 8'hA0);
    lose <= 1'h1;
    apb(1'h1, 12'h004, 8'h00);
    pause(6);
    rc(12'h000, 8'hA0);
    chk("irq", {31'h0, generator_irq}, 32'h0);
    apb(1'h1, 12'h000, 8'h30);
    wait_req <= 1'h1;
    stop_req <= 1'h1;
    pause(5);
    chk("loop", {31'h0, loop_enable}, 32'h1);
    wait_req <= 1'h0;
    pause(5);
    chk("loop", {31'h0, loop_enable}, 32'h0);
    a = oscillator_clock;
    pause(1);
    chk("osc", {31'h0, oscillator_clock}, {31'h0, a});
    wake();
    rc(12'h000, 8'h20);
    osc_en <= 1'h1;
    stop_req <= 1'h1;
    pause(5);
    chk("loop", {31'h0, loop_enable}, 32'h0);
    a = oscillator_clock;
    pause(1);
    chk("osc", {31'h0, oscillator_clock}, {31'h0, ~a});
    wake();
    a = generator_output_clock;
    pause(2);
    chk("outclk", {31'h0, generator_output_clock}, {31'h0, ~a});
    wrap_up();
  end
endmodule : test_plec_top
